//--- common/lane7_status_pkg.sv
// Shared constants and carrier types for the lane 7 link health block.
package lane7_status_pkg;

    // ==========================================================
    // Register indexes; the byte address is four times the index.
    localparam int ADDR_W = 32;
    localparam logic [11:0] IDX_LINK_PAGE = 12'h300;
    localparam logic [11:0] IDX_LANE7_HEALTH = 12'h4B7;
    localparam logic [11:0] IDX_IRQ_EN_A = 12'h4B8;
    localparam logic [11:0] IDX_IRQ_STAT_A = 12'h4BA;
    localparam logic [11:0] IDX_ERR_THRESH = 12'h4BF;

    // ==========================================================
    // Field positions shared by health, enable and status bytes.
    localparam int BIT_DISPARITY = 7;
    localparam int BIT_BAD_CODE = 6;
    localparam int BIT_STRAY_K = 5;
    localparam int BIT_DESKEW = 4;
    localparam int BIT_INIT_ALIGN = 3;
    localparam int BIT_CHECKSUM = 2;
    localparam int BIT_FRAME = 1;
    localparam int BIT_CODEGROUP = 0;
    localparam logic [7:0] IRQ_BITS = 8'hF8;
    localparam logic [7:0] ERR_BITS = 8'hE0;
    localparam logic [7:0] LOSS_BITS = 8'h18;

    // ==========================================================
    // Reset values.
    localparam logic [7:0] HEALTH_RST = 8'h00;
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] THRESH_RST = 8'hFF;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h00000000;

    // ==========================================================
    // Lane 7 receive state delivered by one link's receiver.
    typedef struct packed {
        logic [7:0] disparity_cnt;
        logic [7:0] bad_code_cnt;
        logic [7:0] stray_k_cnt;
        logic deskew_ok;
        logic initial_align_ok;
        logic checksum_ok;
        logic frame_lock;
        logic codegroup_lock;
    } lane7_in_t;

endpackage

//--- src/lane_flag_eval.sv
// Registered lane 7 health flags and their change events for one link.
`timescale 1ns/1ps
module lane_flag_eval (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Lane state and threshold
    input wire lane7_status_pkg::lane7_in_t lane_in,
    input wire logic [7:0] thresh,
    // Flags and events
    output logic [7:0] flags,
    output logic [7:0] events
);
    typedef struct packed {
        logic [7:0] flags;
    } eval_state_t;

    eval_state_t state_reg;
    eval_state_t state_next;

    function automatic logic at_limit(input logic [7:0] cnt, input logic [7:0] lim);
        return cnt >= lim;
    endfunction

    // ==========================================================
    // Flag evaluation.
    always_comb begin
        state_next = state_reg;
        state_next.flags[lane7_status_pkg::BIT_DISPARITY] = at_limit(lane_in.disparity_cnt, thresh);
        state_next.flags[lane7_status_pkg::BIT_BAD_CODE] = at_limit(lane_in.bad_code_cnt, thresh);
        state_next.flags[lane7_status_pkg::BIT_STRAY_K] = at_limit(lane_in.stray_k_cnt, thresh);
        state_next.flags[lane7_status_pkg::BIT_DESKEW] = lane_in.deskew_ok;
        state_next.flags[lane7_status_pkg::BIT_INIT_ALIGN] = lane_in.initial_align_ok;
        state_next.flags[lane7_status_pkg::BIT_CHECKSUM] = lane_in.checksum_ok;
        state_next.flags[lane7_status_pkg::BIT_FRAME] = lane_in.frame_lock;
        state_next.flags[lane7_status_pkg::BIT_CODEGROUP] = lane_in.codegroup_lock;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{flags: lane7_status_pkg::HEALTH_RST};
        end else begin
            state_reg <= state_next;
        end
    end

    // Errors raise an event when they reach the limit, deskew and initial alignment bits when they drop.
    assign events = (state_next.flags & ~state_reg.flags & lane7_status_pkg::ERR_BITS)
                  | (~state_next.flags & state_reg.flags & lane7_status_pkg::LOSS_BITS);
    assign flags = state_reg.flags;

    // ==========================================================
    // Checks.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_bad_code;
        1'b1 |=> flags[6] == ($past(lane_in.bad_code_cnt) >= $past(thresh));
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("bad code flag does not follow the count");
    property p_stray_k;
        lane_in.stray_k_cnt < thresh |=> !flags[5];
    endproperty
    a_stray_k: assert property (p_stray_k)
        else $error("stray control flag set below threshold");
    property p_deskew;
        $fell(lane_in.deskew_ok) |=> !flags[4] && events[4] == 1'b0;
    endproperty
    a_deskew: assert property (p_deskew)
        else $error("deskew flag did not drop");
    property p_init_align;
        lane_in.initial_align_ok ##1 lane_in.initial_align_ok |-> flags[3];
    endproperty
    a_init_align: assert property (p_init_align)
        else $error("initial alignment flag missing");
    property p_checksum;
        1'b1 |=> flags[2] == $past(lane_in.checksum_ok);
    endproperty
    a_checksum: assert property (p_checksum)
        else $error("checksum flag wrong");
    property p_frame;
        1'b1 |=> flags[1] == $past(lane_in.frame_lock);
    endproperty
    a_frame: assert property (p_frame)
        else $error("frame lock flag wrong");
    property p_codegroup;
        1'b1 |=> flags[0] == $past(lane_in.codegroup_lock);
    endproperty
    a_codegroup: assert property (p_codegroup)
        else $error("code group lock flag wrong");
endmodule

//--- src/irq_event_latch.sv
// Sticky event bits, cleared by a write of one, where a new event wins.
`timescale 1ns/1ps
module irq_event_latch #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Events and clears
    input wire logic [W-1:0] set_bits,
    input wire logic [W-1:0] clr_bits,
    // Sticky state
    output logic [W-1:0] status
);
    typedef struct packed {
        logic [W-1:0] status;
    } latch_state_t;

    latch_state_t state_reg;
    latch_state_t state_next;

    always_comb begin
        state_next.status = (state_reg.status & ~clr_bits) | set_bits;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{status: W'(lane7_status_pkg::STAT_RST)};
        end else begin
            state_reg <= state_next;
        end
    end

    assign status = state_reg.status;

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (set_bits & clr_bits) != '0 |=> (status & $past(set_bits)) == $past(set_bits);
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost against a clear");
endmodule

//--- src/lane7_link_status_irq_enable.sv
// Paged lane 7 link health and interrupt enable registers behind APB.
//
// Function
// - Not-in-table flag, bit 6, is high while count is at or above threshold.
// - Unexpected control character flag, bit 5, high at or above threshold.
// - Bit 4 reads one when deskew achieved, zero when failed.
// - Bit 3 reads one when initial lane alignment achieved, zero when lost.
// - Bit 2 reads one when checksum correct, zero when incorrect.
// - Bit 1 reads one when frame lock achieved, zero when lost.
// - Bit 0 shows code group lock; all health flags read-only, reset zero.
// - All fields are paged by the link page register at index 0x300.
// - Enable bit 7 lets the disparity counter interrupt; read/write, resets zero.
// - Enable bit 6 lets the bad code counter interrupt; resets zero.
// - Enable bit 5 lets the stray control counter interrupt; resets zero.
// - Enable bit 4 lets a deskew condition interrupt; resets zero.
// - Enable bit 3 lets an initial alignment condition interrupt; resets zero.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module lane7_link_status_irq_enable #(
    parameter int NUM_LINKS = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,

    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Lane 7 receive state, one entry per link
    input wire lane7_status_pkg::lane7_in_t [NUM_LINKS-1:0] lane_in,

    // Interrupt
    output logic irq
);

    // ==========================================================
    // State.
    localparam int PAGE_W = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic [7:0] link_page;
        logic [NUM_LINKS-1:0][7:0] irq_en;
        logic [NUM_LINKS-1:0][7:0] thresh;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;

    // ==========================================================
    // Address decode.
    function automatic logic reg_hit(input logic [31:0] addr, input logic [11:0] idx);
        return addr == {18'h00000, idx, 2'b00};
    endfunction

    logic [NUM_LINKS-1:0][7:0] flags;
    logic [NUM_LINKS-1:0][7:0] events;
    logic [NUM_LINKS-1:0][7:0] status;
    logic [NUM_LINKS-1:0][7:0] clr;
    logic access;
    logic commit;
    logic wr_commit;
    logic hit_page;
    logic hit_health;
    logic hit_en;
    logic hit_stat;
    logic hit_thr;
    logic mapped;
    logic page_ok;
    logic any_pending;
    logic new_enabled_event;
    logic [PAGE_W-1:0] pidx;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic [7:0] sel_flags;
    logic [7:0] sel_status;
    logic [7:0] sel_en;
    logic [7:0] sel_thr;

    assign hit_page = reg_hit(paddr, lane7_status_pkg::IDX_LINK_PAGE);
    assign hit_health = reg_hit(paddr, lane7_status_pkg::IDX_LANE7_HEALTH);
    assign hit_en = reg_hit(paddr, lane7_status_pkg::IDX_IRQ_EN_A);
    assign hit_stat = reg_hit(paddr, lane7_status_pkg::IDX_IRQ_STAT_A);
    assign hit_thr = reg_hit(paddr, lane7_status_pkg::IDX_ERR_THRESH);
    assign mapped = hit_page | hit_health | hit_en | hit_stat | hit_thr;

    // One wait state: pready rises one edge into the access phase.
    // Writes land only at the edge where pready is seen high.
    assign access = psel && penable;
    assign commit = access && state_reg.pready;
    assign wr_commit = commit && pwrite && pstrb[0] && mapped;
    assign wbyte = pwdata[7:0];

    // A page beyond the last link reads zero and swallows writes.
    assign page_ok = state_reg.link_page < 8'(NUM_LINKS);
    assign pidx = state_reg.link_page[PAGE_W-1:0];

    // ==========================================================
    // Per-link flag evaluation and sticky event bits.
    for (genvar l = 0; l < NUM_LINKS; l++) begin : g_link
        lane_flag_eval u_eval (
            .pclk(pclk),
            .presetn(presetn),
            .lane_in(lane_in[l]),
            .thresh(state_reg.thresh[l]),
            .flags(flags[l]),
            .events(events[l])
        );

        irq_event_latch #(
            .W(8)
        ) u_latch (
            .pclk(pclk),
            .presetn(presetn),
            .set_bits(events[l] & lane7_status_pkg::IRQ_BITS),
            .clr_bits(clr[l]),
            .status(status[l])
        );

        assign clr[l] = (wr_commit && hit_stat && page_ok && pidx == PAGE_W'(l))
                      ? (wbyte & lane7_status_pkg::IRQ_BITS) : 8'h00;
    end

    // ==========================================================
    // Page selection for reads.
    always_comb begin
        sel_flags = 8'h00;
        sel_status = 8'h00;
        sel_en = 8'h00;
        sel_thr = 8'h00;
        for (int l = 0; l < NUM_LINKS; l++) begin
            if (page_ok && pidx == PAGE_W'(l)) begin
                sel_flags = flags[l];
                sel_status = status[l];
                sel_en = state_reg.irq_en[l];
                sel_thr = state_reg.thresh[l];
            end
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (hit_page) begin
            rd_byte = state_reg.link_page;
        end else if (hit_health) begin
            rd_byte = sel_flags;
        end else if (hit_en) begin
            rd_byte = sel_en;
        end else if (hit_stat) begin
            rd_byte = sel_status;
        end else if (hit_thr) begin
            rd_byte = sel_thr;
        end
    end

    // ==========================================================
    // Interrupt gating over every link, not only the page shown.
    always_comb begin
        any_pending = 1'b0;
        for (int l = 0; l < NUM_LINKS; l++) begin
            if ((status[l] & state_reg.irq_en[l]) != 8'h00) begin
                any_pending = 1'b1;
            end
        end
    end

    // Fresh enabled events on any link; the raise check must see every page, not only link 0.
    always_comb begin
        new_enabled_event = 1'b0;
        for (int l = 0; l < NUM_LINKS; l++) begin
            if ((events[l] & state_reg.irq_en[l] & lane7_status_pkg::IRQ_BITS) != 8'h00) begin
                new_enabled_event = 1'b1;
            end
        end
    end

    // ==========================================================
    // Next state.
    always_comb begin
        state_next = state_reg;
        state_next.irq = any_pending;
        if (access && !state_reg.pready) begin
            state_next.pready = 1'b1;
            state_next.pslverr = !mapped;
            state_next.prdata = {24'h000000, rd_byte};
        end else if (commit) begin
            state_next.pready = 1'b0;
            state_next.pslverr = 1'b0;
            if (wr_commit && hit_page) begin
                state_next.link_page = wbyte;
            end
            if (wr_commit && hit_thr && page_ok) begin
                state_next.thresh[pidx] = wbyte;
            end
            if (wr_commit && hit_en && page_ok) begin
                state_next.irq_en[pidx][lane7_status_pkg::BIT_DISPARITY] =
                    wbyte[lane7_status_pkg::BIT_DISPARITY];
                state_next.irq_en[pidx][lane7_status_pkg::BIT_BAD_CODE] =
                    wbyte[lane7_status_pkg::BIT_BAD_CODE];
                state_next.irq_en[pidx][lane7_status_pkg::BIT_STRAY_K] =
                    wbyte[lane7_status_pkg::BIT_STRAY_K];
                state_next.irq_en[pidx][lane7_status_pkg::BIT_DESKEW] =
                    wbyte[lane7_status_pkg::BIT_DESKEW];
                state_next.irq_en[pidx][lane7_status_pkg::BIT_INIT_ALIGN] =
                    wbyte[lane7_status_pkg::BIT_INIT_ALIGN];
            end
        end
    end

    // ==========================================================
    // Registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{
                pready: 1'b0,
                pslverr: 1'b0,
                prdata: lane7_status_pkg::RDATA_RST,
                irq: 1'b0,
                link_page: lane7_status_pkg::PAGE_RST,
                irq_en: {NUM_LINKS{lane7_status_pkg::IRQ_EN_RST}},
                thresh: {NUM_LINKS{lane7_status_pkg::THRESH_RST}}
            };
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign irq = state_reg.irq;

    // ==========================================================
    // Checks.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_answer;
        access && !pready |=> pready ##1 !pready;
    endproperty
    a_answer: assert property (p_answer)
        else $error("answer not given after one wait state");

    property p_unmapped;
        access && !pready && !mapped |=> pready && pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not flagged");

    property p_health_paged;
        access && !pready && hit_health |=> prdata == {24'h000000, $past(sel_flags)};
    endproperty
    a_health_paged: assert property (p_health_paged)
        else $error("health read not from selected link");

    property p_en_disparity;
        wr_commit && hit_en && page_ok
        |=> state_reg.irq_en[$past(pidx)][7] == $past(pwdata[7]);
    endproperty
    a_en_disparity: assert property (p_en_disparity)
        else $error("disparity enable not written");

    property p_en_bad_code;
        wr_commit && hit_en && page_ok
        |=> state_reg.irq_en[$past(pidx)][6] == $past(pwdata[6]);
    endproperty
    a_en_bad_code: assert property (p_en_bad_code)
        else $error("bad code enable not written");

    property p_en_stray_k;
        wr_commit && hit_en && page_ok
        |=> state_reg.irq_en[$past(pidx)][5] == $past(pwdata[5]);
    endproperty
    a_en_stray_k: assert property (p_en_stray_k)
        else $error("stray control enable not written");

    property p_en_deskew;
        wr_commit && hit_en && page_ok
        |=> state_reg.irq_en[$past(pidx)][4] == $past(pwdata[4]);
    endproperty
    a_en_deskew: assert property (p_en_deskew)
        else $error("deskew enable not written");

    property p_en_init_align;
        wr_commit && hit_en && page_ok
        |=> state_reg.irq_en[$past(pidx)][3] == $past(pwdata[3]);
    endproperty
    a_en_init_align: assert property (p_en_init_align)
        else $error("initial alignment enable not written");

    property p_irq_raise;
        new_enabled_event
        && !(wr_commit && hit_en) |-> ##2 irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("enabled event did not raise the interrupt");

    property p_irq_quiet;
        !any_pending ##1 !any_pending |-> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt high with nothing enabled pending");

    property p_page_write;
        wr_commit && hit_page |=> state_reg.link_page == $past(wbyte);
    endproperty
    a_page_write: assert property (p_page_write)
        else $error("link page not written");

    property p_thresh_write;
        wr_commit && hit_thr && page_ok |=> state_reg.thresh[$past(pidx)] == $past(wbyte);
    endproperty
    a_thresh_write: assert property (p_thresh_write)
        else $error("threshold not written to the paged link");

    property p_off_page;
        commit && !page_ok |=> $stable(state_reg.irq_en) && $stable(state_reg.thresh);
    endproperty
    a_off_page: assert property (p_off_page)
        else $error("access beyond the last page changed a link");

    property p_off_read;
        access && !pready && !page_ok && !hit_page |=> prdata == 32'h00000000;
    endproperty
    a_off_read: assert property (p_off_read)
        else $error("read beyond the last page not zero");

    property p_health_ro;
        commit && hit_health |=> $stable(state_reg.irq_en) && $stable(state_reg.thresh);
    endproperty
    a_health_ro: assert property (p_health_ro)
        else $error("write to the health register changed state");

endmodule

//--- test/lane_far_end.sv
// Behavioural far end: the link transmitter's view of lane 7 state, one entry per link.
`timescale 1ns/1ps
module lane_far_end #(
    parameter int NUM_LINKS = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Update requests from the bench
    input wire logic upd,
    input wire logic [7:0] upd_link,
    input wire lane7_status_pkg::lane7_in_t upd_val,
    // Lane state seen by the receiver
    output lane7_status_pkg::lane7_in_t [NUM_LINKS-1:0] lane_in
);
    // ==========================================================
    // Lane state
    // A lane that has not trained yet shows no lock and no errors, as a real link would.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_in <= '0;
        end else if (upd) begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                if (upd_link == i[7:0]) begin
                    lane_in[i] <= upd_val;
                end
            end
        end
    end
endmodule

//--- test/lane7_link_status_irq_enable_tb.sv
// Self-checking bench for the paged lane 7 health and interrupt enable registers.
`timescale 1ns/1ps
module lane7_link_status_irq_enable_tb;
    // ==========================================================
    // Signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    lane7_status_pkg::lane7_in_t [1:0] lane_in;
    logic upd = 1'b0;
    logic [7:0] upd_link = 8'h00;
    lane7_status_pkg::lane7_in_t upd_val = '0;
    typedef struct {logic rd; logic err; logic [31:0] data; string nm;} note_t;
    note_t notes[$];
    note_t cur;
    int mismatches = 0;
    int samples_checked = 0;
    logic [4:0] lk;
    logic [7:0] cnt;

    lane7_link_status_irq_enable #(.NUM_LINKS(2)) lane7_link_status_irq_enable_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lane_in(lane_in), .irq(irq));
    lane_far_end #(.NUM_LINKS(2)) lane_far_end_inst (
        .pclk(pclk), .presetn(presetn), .upd(upd), .upd_link(upd_link), .upd_val(upd_val),
        .lane_in(lane_in));

    initial begin
        forever #5 pclk = ~pclk;
    end

    // ==========================================================
    // Reporting
    task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // Drivers
    // The leading edge wait keeps a released psel from being raised again in the same step.
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd, input logic [7:0] ex,
                       input logic er, input string nm);
        int n;
        note_t e;
        e.rd = ~wr;
        e.err = er;
        e.data = {24'h0, ex};
        e.nm = nm;
        n = 0;
        notes.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {18'h0, idx, 2'b00};
        pwdata <= {24'h0, wd};
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            mismatches++;
            finish_test();
        end
    endtask

    task automatic set_lane(input logic [7:0] link, input lane7_status_pkg::lane7_in_t v);
        @(posedge pclk);
        upd <= 1'b1;
        upd_link <= link;
        upd_val <= v;
        @(posedge pclk);
        upd <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic wait_irq(input logic v, input string nm);
        int n;
        n = 0;
        while (irq !== v && n < 8) begin
            @(posedge pclk);
            n++;
        end
        check(nm, {31'h0, v}, {31'h0, irq});
    endtask

    // ==========================================================
    // Answer monitor: every completed transfer retires the oldest note.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (notes.size() == 0) begin
                mismatches++;
                $display("Error apb_answer expected none seen one");
            end else begin
                cur = notes.pop_front();
                check({cur.nm, "_err"}, {31'h0, cur.err}, {31'h0, pslverr});
                if (cur.rd && !cur.err) begin
                    check(cur.nm, cur.data, prdata);
                end
            end
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        finish_test();
    end

    // ==========================================================
    // Scenarios
    initial begin
        void'($urandom(32'h2EFD));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, lane7_status_pkg::IDX_LANE7_HEALTH, 8'h00, 8'h00, 1'b0, "health_rst");
        apb(1'b0, lane7_status_pkg::IDX_IRQ_EN_A, 8'h00, 8'h00, 1'b0, "irq_en_rst");
        apb(1'b0, 12'h123, 8'h00, 8'h00, 1'b1, "unmapped");
        for (int b = 3; b < 8; b++) begin
            apb(1'b1, lane7_status_pkg::IDX_IRQ_EN_A, 8'h01 << b, 8'h00, 1'b0, "irq_en_wr");
            apb(1'b0, lane7_status_pkg::IDX_IRQ_EN_A, 8'h00, 8'h01 << b, 1'b0, "irq_en_bit");
        end
        apb(1'b1, lane7_status_pkg::IDX_IRQ_EN_A, 8'hFF, 8'h00, 1'b0, "irq_en_wr");
        apb(1'b0, lane7_status_pkg::IDX_IRQ_EN_A, 8'h00, 8'hF8, 1'b0, "irq_en_all");
        apb(1'b1, lane7_status_pkg::IDX_IRQ_EN_A, 8'h00, 8'h00, 1'b0, "irq_en_wr");
        // Counts just below, at and above the threshold, with random lock bits on link 0.
        apb(1'b1, lane7_status_pkg::IDX_ERR_THRESH, 8'h10, 8'h00, 1'b0, "thresh_wr");
        for (int i = 0; i < 3; i++) begin
            cnt = 8'h0F + i[7:0];
            lk = 5'($urandom);
            set_lane(8'h00, {cnt, cnt, cnt, lk});
            apb(1'b0, lane7_status_pkg::IDX_LANE7_HEALTH, 8'h00, {{3{cnt >= 8'h10}}, lk}, 1'b0, "health");
        end
        apb(1'b1, lane7_status_pkg::IDX_LANE7_HEALTH, 8'hAA, 8'h00, 1'b0, "health_wr");
        apb(1'b0, lane7_status_pkg::IDX_LANE7_HEALTH, 8'h00, {{3{cnt >= 8'h10}}, lk}, 1'b0, "health_ro");
        wait_irq(1'b0, "irq_masked");
        // Link 1 has its own health, threshold and enables.
        set_lane(8'h01, {8'h01, 8'h00, 8'h00, 5'b10101});
        apb(1'b1, lane7_status_pkg::IDX_LINK_PAGE, 8'h01, 8'h00, 1'b0, "page_wr");
        apb(1'b0, lane7_status_pkg::IDX_LINK_PAGE, 8'h00, 8'h01, 1'b0, "page_rd");
        apb(1'b0, lane7_status_pkg::IDX_LANE7_HEALTH, 8'h00, 8'h15, 1'b0, "health_p1");
        apb(1'b1, lane7_status_pkg::IDX_IRQ_EN_A, 8'h10, 8'h00, 1'b0, "irq_en_wr");
        set_lane(8'h01, {8'h01, 8'h00, 8'h00, 5'b00101});
        wait_irq(1'b1, "irq_deskew");
        apb(1'b0, lane7_status_pkg::IDX_IRQ_STAT_A, 8'h00, 8'h10, 1'b0, "stat_p1");
        apb(1'b1, lane7_status_pkg::IDX_IRQ_STAT_A, 8'h10, 8'h00, 1'b0, "stat_clr");
        wait_irq(1'b0, "irq_cleared");
        apb(1'b1, lane7_status_pkg::IDX_LINK_PAGE, 8'h02, 8'h00, 1'b0, "page_wr");
        apb(1'b0, lane7_status_pkg::IDX_LANE7_HEALTH, 8'h00, 8'h00, 1'b0, "health_p2");
        apb(1'b1, lane7_status_pkg::IDX_LINK_PAGE, 8'h00, 8'h00, 1'b0, "page_wr");
        apb(1'b0, lane7_status_pkg::IDX_IRQ_EN_A, 8'h00, 8'h00, 1'b0, "irq_en_p0");
        // Link 0 kept its threshold event while masked; enabling now must raise the request.
        apb(1'b1, lane7_status_pkg::IDX_IRQ_EN_A, 8'h40, 8'h00, 1'b0, "irq_en_wr");
        wait_irq(1'b1, "irq_bad_code");
        apb(1'b1, lane7_status_pkg::IDX_IRQ_STAT_A, 8'hF8, 8'h00, 1'b0, "stat_clr");
        wait_irq(1'b0, "irq_all_clear");
        apb(1'b0, lane7_status_pkg::IDX_IRQ_STAT_A, 8'h00, 8'h00, 1'b0, "stat_p0");
        // A clear that meets a fresh threshold event in the same cycle must lose to it.
        set_lane(8'h00, {24'h000000, lk});
        fork
            begin
                @(posedge pclk);
                set_lane(8'h00, {24'h202020, lk});
            end
            apb(1'b1, lane7_status_pkg::IDX_IRQ_STAT_A, 8'hF8, 8'h00, 1'b0, "stat_clr");
        join
        apb(1'b0, lane7_status_pkg::IDX_IRQ_STAT_A, 8'h00, 8'hE0, 1'b0, "stat_set_wins");
        wait_irq(1'b1, "irq_set_wins");
        repeat (2) @(posedge pclk);
        finish_test();
    end
endmodule
